// ---- pkg/usbe_consts.svh ----
// Register indices, field positions, mode codes and reset values.
`ifndef USBE_CONSTS_SVH
`define USBE_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define USBE_IDX_A0_CNT   8'h11
`define USBE_IDX_A0_MODE  8'h12
`define USBE_IDX_A1_CNT   8'h13
`define USBE_IDX_A1_MODE  8'h14
`define USBE_IDX_A2_CNT   8'h15
`define USBE_IDX_A2_MODE  8'h16
`define USBE_IDX_CFG      8'h1f
`define USBE_IDX_B0_CNT   8'h41
`define USBE_IDX_B0_MODE  8'h42
`define USBE_IDX_B1_CNT   8'h43
`define USBE_IDX_B1_MODE  8'h44

// Endpoint slots.
`define USBE_SLOTS        5
`define USBE_SLOT_A0      3'h0
`define USBE_SLOT_B0      3'h3

// Mode register fields.
`define USBE_B_SETUP      7
`define USBE_B_STALL      7
`define USBE_B_IN         6
`define USBE_B_OUT        5
`define USBE_B_ACK        4
`define USBE_B_MODE_HI    3

// Counter register fields.
`define USBE_B_TOGGLE     7
`define USBE_B_VALID      6
`define USBE_B_CNT_HI     5
`define USBE_CRC_BYTES    6'h02

// Configuration bits kept in the status and control register.
`define USBE_B_CFG_SIZE   7
`define USBE_B_CFG_5EP    6

`define USBE_REG_RST      8'h00
`define USBE_CFG_MASK     8'hc0

// Mode field codes.
`define USBE_M_DISABLE    4'h0
`define USBE_M_NAK_INOUT  4'h1
`define USBE_M_ST_OUT     4'h2
`define USBE_M_STALL_IO   4'h3
`define USBE_M_IGN_IO     4'h4
`define USBE_M_ISO_OUT    4'h5
`define USBE_M_ST_IN      4'h6
`define USBE_M_ISO_IN     4'h7
`define USBE_M_NAK_OUT    4'h8
`define USBE_M_ACK_OUT    4'h9
`define USBE_M_NAK_OUT_SI 4'ha
`define USBE_M_ACK_OUT_SI 4'hb
`define USBE_M_NAK_IN     4'hc
`define USBE_M_ACK_IN     4'hd
`define USBE_M_NAK_IN_SO  4'he
`define USBE_M_ACK_IN_SO  4'hf

// Bus responses.
`define USBE_RESP_OKAY    2'h0
`define USBE_RESP_SLVERR  2'h2

`endif

// ---- pkg/usbe_pkg.sv ----
// Types shared by the endpoint mode and counter register block.
package usbe_pkg;

  typedef enum logic [1:0] {
    USBE_PID_SETUP,
    USBE_PID_IN,
    USBE_PID_OUT
  } usbe_pid_t;

  typedef enum logic [2:0] {
    USBE_ANS_IGNORE,
    USBE_ANS_ACK,
    USBE_ANS_NAK,
    USBE_ANS_STALL,
    USBE_ANS_TX_COUNT,
    USBE_ANS_TX_ZERO,
    USBE_ANS_CHECK
  } usbe_ans_t;

endpackage

// ---- src/usbe_mode_count_regs.sv ----
// Endpoint mode and byte-count registers with endpoint zero write locking.
//
// Contract
// - Four-bit mode field decides each endpoint's answer to SETUP, IN, OUT.
// - Engine sets ACK flag when a transaction ends with an ACK handshake.
// - Engine sets endpoint 0 OUT flag on OUT token; firmware clears it.
// - Engine sets endpoint 0 IN flag on IN token; firmware clears it.
// - Only engine sets SETUP flag; a CPU write to it clears it unless the flag is forced.
// - SETUP flag forced high from SETUP data start to ACK start.
// - In five-endpoint configuration, B0 mode register acts as non-control.
// - Engine update locks endpoint 0 mode bits 6:0 until a CPU read.
// - Only endpoint 0 mode registers lock; others always stay writable.
// - CPU writes to endpoint zero FIFO ignored while SETUP flag set.
// - No ACK-OUT with NAK-IN mode; SETUP may overwrite previous payload.
// - Stall bit stalls OUT in ACK-IN and IN in ACK-OUT modes.
// - After OUT or SETUP, byte count is received bytes plus two.
// - Data-valid follows CRC result; endpoint event raised either way.
// - Toggle selects DATA0/DATA1; engine stores received toggle.
// - Endpoint 0 counter locks on SETUP/OUT update until CPU read.
// - Five counter registers share one layout: count, valid, toggle.
// - After ACK in an acknowledge mode, engine drops to its NAK mode.
// - SETUP on a non-disabled control endpoint forces mode NAK IN/OUT.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "usbe_consts.svh"

module usbe_mode_count_regs #(
  parameter int ADDR_W = 12
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  input  wire logic                 sie_tok_valid,
  input  wire logic [2:0]           sie_tok_ep,
  input  wire usbe_pkg::usbe_pid_t  sie_tok_pid,
  output logic                      ans_valid,
  output usbe_pkg::usbe_ans_t       ans_code,
  output logic [5:0]                ans_count,
  output logic                      ans_toggle,
  input  wire logic                 sie_setup_start,
  input  wire logic                 sie_ack_start,
  input  wire logic [2:0]           sie_phase_ep,
  input  wire logic                 sie_upd_valid,
  input  wire logic [2:0]           sie_upd_ep,
  input  wire usbe_pkg::usbe_pid_t  sie_upd_pid,
  input  wire logic                 sie_upd_acked,
  input  wire logic [5:0]           sie_upd_count,
  input  wire logic                 sie_upd_crc_ok,
  input  wire logic                 sie_upd_toggle,
  input  wire logic                 fifo_wr_req,
  input  wire logic [2:0]           fifo_wr_ep,
  output logic                      fifo_wr_en,
  output logic [4:0]                ep_event
);
  import usbe_pkg::*;

  localparam int NS = `USBE_SLOTS;

  logic [7:0]        mode_r [NS];
  logic [7:0]        mode_nxt [NS];
  logic [7:0]        cnt_r [NS];
  logic [7:0]        cnt_nxt [NS];
  logic [NS-1:0]     mode_lock_r;
  logic [NS-1:0]     cnt_lock_r;
  logic [NS-1:0]     setup_force_r;
  logic [NS-1:0]     ctrl;
  logic [NS-1:0]     upd_hit;
  logic [NS-1:0]     wr_mode;
  logic [NS-1:0]     wr_cnt;
  logic [NS-1:0]     rd_mode;
  logic [NS-1:0]     rd_cnt;
  logic [7:0]        cfg_r;
  logic              aw_held_r;
  logic              w_held_r;
  logic [7:0]        aw_idx_r;
  logic              aw_ok_r;
  logic [7:0]        w_data_r;
  logic              w_lane_r;
  logic              wr_go;
  logic              rd_go;
  logic [7:0]        ar_idx;
  logic              ar_ok;
  logic [7:0]        rd_val;
  logic              rd_hit;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  logic              ans_valid_r;
  usbe_ans_t         ans_code_r;
  logic [5:0]        ans_count_r;
  logic              ans_toggle_r;
  logic [4:0]        ep_event_r;

  // Index of the mode and counter register of each slot.
  function automatic logic [7:0] mode_idx(input int s);
    case (s)
      0:       mode_idx = `USBE_IDX_A0_MODE;
      1:       mode_idx = `USBE_IDX_A1_MODE;
      2:       mode_idx = `USBE_IDX_A2_MODE;
      3:       mode_idx = `USBE_IDX_B0_MODE;
      default: mode_idx = `USBE_IDX_B1_MODE;
    endcase
  endfunction

  function automatic logic [7:0] cnt_idx(input int s);
    case (s)
      0:       cnt_idx = `USBE_IDX_A0_CNT;
      1:       cnt_idx = `USBE_IDX_A1_CNT;
      2:       cnt_idx = `USBE_IDX_A2_CNT;
      3:       cnt_idx = `USBE_IDX_B0_CNT;
      default: cnt_idx = `USBE_IDX_B1_CNT;
    endcase
  endfunction

  // Answer to a token from the mode field and the stall bit.
  function automatic usbe_ans_t answer(input logic [3:0] m,
                                       input logic stall,
                                       input usbe_pid_t pid);
    logic setup_ok;
    usbe_ans_t a_in;
    usbe_ans_t a_out;
    setup_ok = 1'b0;
    a_in = USBE_ANS_IGNORE;
    a_out = USBE_ANS_IGNORE;
    unique case (m)
      `USBE_M_DISABLE: ;
      `USBE_M_NAK_INOUT: begin
        setup_ok = 1'b1;
        a_in = USBE_ANS_NAK;
        a_out = USBE_ANS_NAK;
      end
      `USBE_M_ST_OUT: begin
        setup_ok = 1'b1;
        a_in = USBE_ANS_STALL;
        a_out = USBE_ANS_CHECK;
      end
      `USBE_M_STALL_IO: begin
        setup_ok = 1'b1;
        a_in = USBE_ANS_STALL;
        a_out = USBE_ANS_STALL;
      end
      `USBE_M_IGN_IO: setup_ok = 1'b1;
      `USBE_M_ISO_OUT: a_out = USBE_ANS_ACK;
      `USBE_M_ST_IN: begin
        setup_ok = 1'b1;
        a_in = USBE_ANS_TX_ZERO;
        a_out = USBE_ANS_STALL;
      end
      `USBE_M_ISO_IN: a_in = USBE_ANS_TX_COUNT;
      `USBE_M_NAK_OUT: a_out = USBE_ANS_NAK;
      `USBE_M_ACK_OUT: begin
        a_in = stall ? USBE_ANS_STALL : USBE_ANS_IGNORE;
        a_out = USBE_ANS_ACK;
      end
      `USBE_M_NAK_OUT_SI: begin
        setup_ok = 1'b1;
        a_in = USBE_ANS_TX_ZERO;
        a_out = USBE_ANS_NAK;
      end
      `USBE_M_ACK_OUT_SI: begin
        setup_ok = 1'b1;
        a_in = USBE_ANS_TX_ZERO;
        a_out = USBE_ANS_ACK;
      end
      `USBE_M_NAK_IN: a_in = USBE_ANS_NAK;
      `USBE_M_ACK_IN: begin
        a_in = USBE_ANS_TX_COUNT;
        a_out = stall ? USBE_ANS_STALL : USBE_ANS_IGNORE;
      end
      `USBE_M_NAK_IN_SO: begin
        setup_ok = 1'b1;
        a_in = USBE_ANS_NAK;
        a_out = USBE_ANS_CHECK;
      end
      `USBE_M_ACK_IN_SO: begin
        setup_ok = 1'b1;
        a_in = USBE_ANS_TX_COUNT;
        a_out = USBE_ANS_CHECK;
      end
    endcase
    unique case (pid)
      USBE_PID_SETUP: answer = setup_ok ? USBE_ANS_ACK : USBE_ANS_IGNORE;
      USBE_PID_IN:    answer = a_in;
      default:        answer = a_out;
    endcase
  endfunction

  // Bus side: address and data may arrive in either order.
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready  = !w_held_r;
  assign s_axi_arready = !rvalid_r;
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;
  assign rd_go = s_axi_arvalid && !rvalid_r;
  assign ar_idx = s_axi_araddr[9:2];
  assign ar_ok = (s_axi_araddr[ADDR_W-1:10] == '0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_idx_r  <= 8'h00;
      aw_ok_r   <= 1'b0;
    end else if (s_axi_awvalid && !aw_held_r) begin
      aw_held_r <= 1'b1;
      aw_idx_r  <= s_axi_awaddr[9:2];
      aw_ok_r   <= (s_axi_awaddr[ADDR_W-1:10] == '0);
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
    end else if (s_axi_wvalid && !w_held_r) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata[7:0];
      w_lane_r <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  // Read multiplexer; an unmapped index answers with an error.
  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b0;
    if (ar_idx == `USBE_IDX_CFG) begin
      rd_val = cfg_r;
      rd_hit = 1'b1;
    end
    for (int s = 0; s < NS; s++) begin
      if (ar_idx == mode_idx(s)) begin
        rd_val = mode_r[s];
        rd_hit = 1'b1;
      end
      if (ar_idx == cnt_idx(s)) begin
        rd_val = cnt_r[s];
        rd_hit = 1'b1;
      end
    end
    rd_hit = rd_hit && ar_ok;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `USBE_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (aw_ok_r && (aw_idx_r == `USBE_IDX_CFG ||
                   |(wr_mode | wr_cnt))) ? `USBE_RESP_OKAY
                                         : `USBE_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `USBE_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h00_0000, rd_val};
      rresp_r  <= rd_hit ? `USBE_RESP_OKAY : `USBE_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= `USBE_REG_RST;
    end else if (wr_go && aw_ok_r && w_lane_r &&
                 aw_idx_r == `USBE_IDX_CFG) begin
      cfg_r <= w_data_r & `USBE_CFG_MASK;
    end
  end

  // Per-slot register logic.
  for (genvar s = 0; s < NS; s++) begin : g_slot
    localparam logic [2:0] SL = 3'(s);

    // Slot A0 is always a control endpoint; B0 only in the two-address map.
    if (s == 0) begin : g_c0
      assign ctrl[s] = 1'b1;
    end else if (SL == `USBE_SLOT_B0) begin : g_cb
      assign ctrl[s] = !cfg_r[`USBE_B_CFG_5EP];
    end else begin : g_nc
      assign ctrl[s] = 1'b0;
    end

    assign upd_hit[s] = sie_upd_valid && sie_upd_ep == SL;
    assign wr_mode[s] = wr_go && aw_ok_r && w_lane_r &&
                        aw_idx_r == mode_idx(s);
    assign wr_cnt[s]  = wr_go && aw_ok_r && w_lane_r &&
                        aw_idx_r == cnt_idx(s);
    assign rd_mode[s] = rd_go && ar_ok && ar_idx == mode_idx(s);
    assign rd_cnt[s]  = rd_go && ar_ok && ar_idx == cnt_idx(s);

    // Engine events are applied after the CPU write so that a set wins.
    always_comb begin
      mode_nxt[s] = mode_r[s];
      if (wr_mode[s]) begin
        if (ctrl[s]) begin
          if (!mode_lock_r[s]) begin
            mode_nxt[s][6:0] = w_data_r[6:0];
          end
          if (!setup_force_r[s]) begin
            mode_nxt[s][`USBE_B_SETUP] = 1'b0;
          end
        end else begin
          mode_nxt[s] = w_data_r;
        end
      end
      if (ctrl[s] && sie_setup_start && sie_phase_ep == SL) begin
        mode_nxt[s][`USBE_B_SETUP] = 1'b1;
      end
      if (upd_hit[s]) begin
        if (sie_upd_acked) begin
          mode_nxt[s][`USBE_B_ACK] = 1'b1;
          if (mode_r[s][`USBE_B_MODE_HI] && mode_r[s][0]) begin
            mode_nxt[s][0] = 1'b0;
          end
        end
        if (ctrl[s]) begin
          if (sie_upd_pid == USBE_PID_OUT) begin
            mode_nxt[s][`USBE_B_OUT] = 1'b1;
          end
          if (sie_upd_pid == USBE_PID_IN) begin
            mode_nxt[s][`USBE_B_IN] = 1'b1;
          end
          if (sie_upd_pid == USBE_PID_SETUP &&
              mode_r[s][3:0] != `USBE_M_DISABLE) begin
            mode_nxt[s][3:0] = `USBE_M_NAK_INOUT;
          end
        end
      end
    end

    always_comb begin
      cnt_nxt[s] = cnt_r[s];
      if (wr_cnt[s] && !(ctrl[s] && cnt_lock_r[s])) begin
        cnt_nxt[s] = w_data_r;
      end
      if (upd_hit[s] && sie_upd_pid != USBE_PID_IN) begin
        cnt_nxt[s][`USBE_B_TOGGLE] = sie_upd_toggle;
        cnt_nxt[s][`USBE_B_VALID] = sie_upd_crc_ok;
        cnt_nxt[s][`USBE_B_CNT_HI:0] = sie_upd_count + `USBE_CRC_BYTES;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mode_r[s] <= `USBE_REG_RST;
        cnt_r[s]  <= `USBE_REG_RST;
      end else begin
        mode_r[s] <= mode_nxt[s];
        cnt_r[s]  <= cnt_nxt[s];
      end
    end

    // A read in the update cycle does not unlock: the lock must follow it.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mode_lock_r[s] <= 1'b0;
      end else if (upd_hit[s] && ctrl[s]) begin
        mode_lock_r[s] <= 1'b1;
      end else if (rd_mode[s]) begin
        mode_lock_r[s] <= 1'b0;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_lock_r[s] <= 1'b0;
      end else if (upd_hit[s] && ctrl[s] && sie_upd_pid != USBE_PID_IN) begin
        cnt_lock_r[s] <= 1'b1;
      end else if (rd_cnt[s]) begin
        cnt_lock_r[s] <= 1'b0;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        setup_force_r[s] <= 1'b0;
      end else if (ctrl[s] && sie_setup_start && sie_phase_ep == SL) begin
        setup_force_r[s] <= 1'b1;
      end else if (sie_ack_start && sie_phase_ep == SL) begin
        setup_force_r[s] <= 1'b0;
      end
    end

    // Event raised on every update, whatever the CRC result.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ep_event_r[s] <= 1'b0;
      end else begin
        ep_event_r[s] <= upd_hit[s];
      end
    end
  end

  assign ep_event = ep_event_r;

  // Token answer, one cycle after the token.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ans_valid_r  <= 1'b0;
      ans_code_r   <= USBE_ANS_IGNORE;
      ans_count_r  <= 6'h00;
      ans_toggle_r <= 1'b0;
    end else begin
      ans_valid_r <= sie_tok_valid && sie_tok_ep < 3'(NS);
      if (sie_tok_valid && sie_tok_ep < 3'(NS)) begin
        ans_code_r <= answer(mode_r[sie_tok_ep][3:0],
                             !ctrl[sie_tok_ep] &&
                             mode_r[sie_tok_ep][`USBE_B_STALL],
                             sie_tok_pid);
        ans_count_r  <= cnt_r[sie_tok_ep][`USBE_B_CNT_HI:0];
        ans_toggle_r <= cnt_r[sie_tok_ep][`USBE_B_TOGGLE];
      end
    end
  end

  assign ans_valid  = ans_valid_r;
  assign ans_code   = ans_code_r;
  assign ans_count  = ans_count_r;
  assign ans_toggle = ans_toggle_r;

  // SETUP data in the endpoint zero buffer must survive until read.
  assign fifo_wr_en = fifo_wr_req && fifo_wr_ep < 3'(NS) &&
                      !(ctrl[fifo_wr_ep] &&
                        mode_r[fifo_wr_ep][`USBE_B_SETUP]);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_setup_begin;
    sie_setup_start && sie_phase_ep == `USBE_SLOT_A0;
  endsequence

  // Flag and force rise together; the flag then outlives the force.
  sequence s_setup_held;
    setup_force_r[0] && mode_r[0][`USBE_B_SETUP];
  endsequence

  AST_SETUP_FORCE: assert property (
    setup_force_r[0] |-> mode_r[0][`USBE_B_SETUP])
    else $error("setup flag dropped while forced");

  AST_SETUP_START: assert property (
    s_setup_begin |=> s_setup_held)
    else $error("setup flag not forced at data start");

  AST_SETUP_CLEAR: assert property (
    wr_mode[0] && !setup_force_r[0] && !sie_setup_start
    |=> !mode_r[0][`USBE_B_SETUP])
    else $error("cpu write did not clear setup flag");

  AST_MODE_LOCK: assert property (
    mode_lock_r[0] && wr_mode[0] && !upd_hit[0]
    |=> mode_r[0][6:0] == $past(mode_r[0][6:0]))
    else $error("locked mode bits changed by cpu write");

  AST_MODE_UNLOCK: assert property (
    mode_lock_r[0] && rd_mode[0] && !upd_hit[0] |=> !mode_lock_r[0])
    else $error("read after update did not unlock");

  AST_NC_WRITE: assert property (
    wr_mode[1] && !upd_hit[1] |=> mode_r[1] == $past(w_data_r))
    else $error("non-control mode write lost");

  AST_COUNT: assert property (
    upd_hit[1] && sie_upd_pid == USBE_PID_OUT
    |=> cnt_r[1][5:0] == $past(sie_upd_count) + 6'h02
        && cnt_r[1][6] == $past(sie_upd_crc_ok) && ep_event[1])
    else $error("counter or data valid wrong after OUT");

  AST_CNT_LOCK: assert property (
    cnt_lock_r[0] && wr_cnt[0] && !upd_hit[0] |=> $stable(cnt_r[0]))
    else $error("locked counter written by cpu");

  AST_ACK_NAK: assert property (
    upd_hit[1] && sie_upd_acked && mode_r[1][3:0] == `USBE_M_ACK_OUT
    |=> mode_r[1][3:0] == `USBE_M_NAK_OUT && mode_r[1][`USBE_B_ACK])
    else $error("ack-out did not fall back to nak-out");

  AST_FIFO_BLOCK: assert property (
    mode_r[0][`USBE_B_SETUP] && fifo_wr_ep == 3'h0 |-> !fifo_wr_en)
    else $error("fifo write allowed while setup flag set");

endmodule // usbe_mode_count_regs

// ---- tb/tb.sv ----
// Self-checking bench for the endpoint mode and byte-count registers.
`timescale 1ns/1ps
module tb;
  import usbe_pkg::*;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, fifo_wr_req = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [2:0]  fifo_wr_ep = 3'h0, sie_tok_ep, sie_phase_ep, sie_upd_ep;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, fifo_wr_en, sie_tok_valid, sie_setup_start;
  logic        sie_ack_start, sie_upd_valid, sie_upd_acked, sie_upd_crc_ok;
  logic        sie_upd_toggle, ans_valid, ans_toggle;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [5:0]  sie_upd_count, ans_count;
  logic [4:0]  ep_event;
  usbe_pid_t   sie_tok_pid, sie_upd_pid;
  usbe_ans_t   ans_code;
  int          bad_count = 0;
  int          n_tests = 0;
  // Answer code to an IN token per mode, mode 0 in the lowest nibble.
  logic [63:0] in_ans = 64'h4242550045003320;
  logic [7:0]  regs [11] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
                             8'h1f, 8'h41, 8'h42, 8'h43, 8'h44};

  usbe_mode_count_regs u_dut (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'h1),
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .sie_tok_valid, .sie_tok_ep, .sie_tok_pid,
    .ans_valid, .ans_code, .ans_count, .ans_toggle, .sie_setup_start,
    .sie_ack_start, .sie_phase_ep, .sie_upd_valid, .sie_upd_ep,
    .sie_upd_pid, .sie_upd_acked, .sie_upd_count, .sie_upd_crc_ok,
    .sie_upd_toggle, .fifo_wr_req, .fifo_wr_ep, .fifo_wr_en, .ep_event
  );
  usbe_host_model u_host (
    .aclk, .sie_tok_valid, .sie_tok_ep, .sie_tok_pid, .sie_setup_start,
    .sie_ack_start, .sie_phase_ep, .sie_upd_valid, .sie_upd_ep,
    .sie_upd_pid, .sie_upd_acked, .sie_upd_count, .sie_upd_crc_ok,
    .sie_upd_toggle
  );

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] er = 2'h0);
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(40'(s_axi_bresp), 40'(er));
  endtask

  task automatic rc(input logic [7:0] idx, input logic [7:0] e,
                    input logic [1:0] er = 2'h0);
    @(posedge aclk);
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= {2'h0, idx, 2'h0};
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk({6'h0, s_axi_rresp, s_axi_rdata}, {6'h0, er, 24'h0, e});
  endtask

  task automatic tk(input logic [7:0] m, input usbe_pid_t p,
                    input logic [2:0] e);
    wr(8'h14, m);
    u_host.tok(3'h1, p);
    chk({36'h0, ans_valid, ans_code}, {36'h0, 1'h1, e});
  endtask

  task automatic t_setup();
    fifo_wr_req <= 1'h1;
    wr(8'h12, 8'h01);
    u_host.tok(3'h0, USBE_PID_SETUP);
    chk({36'h0, ans_valid, ans_code}, {36'h0, 1'h1, USBE_ANS_ACK});
    u_host.phase(3'h0, 1'h0);
    rc(8'h12, 8'h81);
    #1 chk({39'h0, fifo_wr_en}, 40'h0);
    u_host.phase(3'h0, 1'h1);
    u_host.upd(3'h0, USBE_PID_SETUP, 3'h6, 6'h08);
    chk({35'h0, ep_event}, 40'h1);
    wr(8'h11, 8'h00);
    rc(8'h11, 8'h4a);
    wr(8'h11, 8'h05);
    rc(8'h11, 8'h05);
    rc(8'h12, 8'h91);
    wr(8'h12, 8'h01);
    rc(8'h12, 8'h01);
    #1 chk({39'h0, fifo_wr_en}, 40'h1);
  endtask

  // Each engine update is followed by a write that the lock must refuse.
  task automatic t_flags();
    wr(8'h12, 8'h0d);
    u_host.upd(3'h0, USBE_PID_IN, 3'h4, 6'h00);
    wr(8'h12, 8'h00);
    rc(8'h12, 8'h5c);
    wr(8'h12, 8'h09);
    u_host.upd(3'h0, USBE_PID_OUT, 3'h7, 6'h00);
    wr(8'h12, 8'h00);
    rc(8'h12, 8'h38);
    rc(8'h11, 8'hc2);
  endtask

  task automatic t_modes();
    wr(8'h13, 8'h85);
    for (int m = 0; m < 16; m++) begin
      tk(8'(m), USBE_PID_IN, in_ans[4*m +: 3]);
    end
    chk({33'h0, ans_toggle, ans_count}, 40'h45);
    tk(8'h89, USBE_PID_IN, USBE_ANS_STALL);
    tk(8'h8d, USBE_PID_OUT, USBE_ANS_STALL);
    tk(8'h09, USBE_PID_OUT, USBE_ANS_ACK);
  endtask

  task automatic t_nonctl();
    u_host.upd(3'h1, USBE_PID_OUT, 3'h5, 6'h04);
    chk({35'h0, ep_event}, 40'h2);
    rc(8'h13, 8'h86);
    rc(8'h14, 8'h18);
    wr(8'h14, 8'h09);
    u_host.upd(3'h1, USBE_PID_OUT, 3'h7, 6'h05);
    wr(8'h14, 8'h0c);
    wr(8'h13, 8'h07);
    rc(8'h14, 8'h0c);
    rc(8'h13, 8'h07);
  endtask

  task automatic t_cfg();
    wr(8'h1f, 8'h40);
    rc(8'h1f, 8'h40);
    wr(8'h42, 8'h89);
    rc(8'h42, 8'h89);
    wr(8'h1f, 8'h00);
    wr(8'h42, 8'h89);
    rc(8'h42, 8'h09);
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (regs[i]) rc(regs[i], 8'h00);
    rc(8'h20, 8'h00, 2'h2);
    wr(8'h20, 8'hff, 2'h2);
    t_setup();
    t_flags();
    t_modes();
    t_nonctl();
    t_cfg();
    conclude();
  end

  // A hung handshake would stall the run; the scenarios need far less.
  initial begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    conclude();
  end
endmodule // tb

// ---- tb/usbe_host_model.sv ----
// Engine-side stand-in that issues tokens, packet phases and updates.
`timescale 1ns/1ps
module usbe_host_model (
  input  wire logic           aclk,
  output logic                sie_tok_valid,
  output logic [2:0]          sie_tok_ep,
  output usbe_pkg::usbe_pid_t sie_tok_pid,
  output logic                sie_setup_start,
  output logic                sie_ack_start,
  output logic [2:0]          sie_phase_ep,
  output logic                sie_upd_valid,
  output logic [2:0]          sie_upd_ep,
  output usbe_pkg::usbe_pid_t sie_upd_pid,
  output logic                sie_upd_acked,
  output logic [5:0]          sie_upd_count,
  output logic                sie_upd_crc_ok,
  output logic                sie_upd_toggle
);
  import usbe_pkg::*;
  initial begin
    {sie_tok_valid, sie_setup_start, sie_ack_start, sie_upd_valid} = 4'h0;
    {sie_tok_ep, sie_phase_ep, sie_upd_ep, sie_upd_count} = 15'h0;
    {sie_upd_acked, sie_upd_crc_ok, sie_upd_toggle} = 3'h0;
    sie_tok_pid = USBE_PID_IN;
    sie_upd_pid = USBE_PID_IN;
  end
  // Released token endpoint, update count and update toggle flip so that a stale value cannot pass for a live one.
  task automatic tok(input logic [2:0] ep, input usbe_pid_t p);
    @(posedge aclk);
    {sie_tok_valid, sie_tok_ep} <= {1'h1, ep};
    sie_tok_pid <= p;
    @(posedge aclk);
    {sie_tok_valid, sie_tok_ep} <= {1'h0, ~ep};
    #1;
  endtask
  task automatic phase(input logic [2:0] ep, input logic ack);
    @(posedge aclk);
    {sie_phase_ep, sie_setup_start, sie_ack_start} <= {ep, !ack, ack};
    @(posedge aclk);
    {sie_setup_start, sie_ack_start} <= 2'h0;
  endtask
  task automatic upd(input logic [2:0] ep, input usbe_pid_t p,
                     input logic [2:0] akt, input logic [5:0] n);
    @(posedge aclk);
    {sie_upd_valid, sie_upd_ep, sie_upd_count} <= {1'h1, ep, n};
    {sie_upd_acked, sie_upd_crc_ok, sie_upd_toggle} <= akt;
    sie_upd_pid <= p;
    @(posedge aclk);
    {sie_upd_valid, sie_upd_count, sie_upd_toggle} <= {1'h0, ~n, ~akt[0]};
    #1;
  endtask
endmodule // usbe_host_model
